// ---- design/rne_pkg.sv ----
// Package with register map, field positions and reset values of the node event logic
//----------------------------------------------------------------------
// Notes on behaviour
// - Event bits latch; register read clears the bits it returned
// - Masked set bit drives pin, status, location
// - Interrupt drops after read or mask clear
// - Self-test run masks its layer's events but self-test done
// - Bad register access sets global fault bit 0
// - Restricted timed writes also set fault bit
// - Physical-layer bit 15 reserved, reads zero
// - Bit 14 sets on signal presence pin
// - Bit 13 sets at link error threshold
// - Bits 12, 11 idle and violation counters
// - Bit 10 sets on physical-layer invalid
// - Bit 9 buffer fault, held until idle/active
// - Bits 8, 7 noise and connection timer zero
// - Bit 6 join, scrub done, active reached
// - Bits 5..3 break, trace line states
// - Bit 2 vector exchange or confidence test done
// - Bit 1 line state equals compare field
// - Bit 0 transmit parity; mask in end station
// - Media bit 15 invalid symbol; receiver listens
// - Bits 14, 13 unrestricted and restricted token
// - Bit 12 token capture, not tokenless start
// - Bit 11 beacon only with R-symbol indicator
// - Source register: global, media, physical bits
package rne_pkg;
  // Register indices; byte address is four times the index
  localparam logic [8:0] IDX_PHY_FLAGS  = 9'h117;
  localparam logic [8:0] IDX_PHY_MASK   = 9'h118;
  localparam logic [8:0] IDX_MAC_FLAGS  = 9'h162;
  localparam logic [8:0] IDX_MAC_MASK   = 9'h163;
  localparam logic [8:0] IDX_GLB_FLAGS  = 9'h184;
  localparam logic [8:0] IDX_GLB_MASK   = 9'h185;
  localparam logic [8:0] IDX_IRQ_SRC    = 9'h186;
  localparam logic [8:0] IDX_CTRL       = 9'h190;
  // Registers of neighbouring blocks that carry timing restrictions
  localparam logic [8:0] IDX_CONN_LOAD  = 9'h191;
  localparam logic [8:0] IDX_NOISE_LOAD = 9'h192;
  localparam logic [8:0] IDX_TX_VECTOR  = 9'h193;
  localparam logic [8:0] IDX_VEC_LENGTH = 9'h194;
  localparam logic [8:0] IDX_MAC_CWRITE = 9'h195;
  // Control register fields
  localparam int CTRL_PHY_RUN = 0;
  localparam int CTRL_MAC_RUN = 1;
  localparam int CTRL_MINI_OVF = 2;
  localparam int CTRL_VSYM_OVF = 3;
  // Source register fields
  localparam int SRC_PHY = 0;
  localparam int SRC_MAC = 1;
  localparam int SRC_GLB = 2;
  // Physical-layer event bit positions
  localparam int PB_SIGNAL = 14;
  localparam int PB_LINKERR = 13;
  localparam int PB_MINI = 12;
  localparam int PB_VSYM = 11;
  localparam int PB_PHY_LAYER_INVALID_EVENT = 10;
  localparam int PB_EBUF = 9;
  localparam int PB_NOISE = 8;
  localparam int PB_CONN = 7;
  localparam int PB_JOIN = 6;
  localparam int PB_BREAK = 5;
  localparam int PB_QUIET = 4;
  localparam int PB_MASTER = 3;
  localparam int PB_CODE = 2;
  localparam int PB_LSEQ = 1;
  localparam int PB_PARITY = 0;
  // Media-access event bit positions
  localparam int MB_PHY_LAYER_INVALID_EVENT = 15;
  localparam int MB_UTOKEN = 14;
  localparam int MB_RTOKEN = 13;
  localparam int MB_TAKEN = 12;
  localparam int MB_BEACON = 11;
  // Reset values
  localparam logic [15:0] RST_FLAGS = 16'h0000;
  localparam logic [15:0] RST_MASK  = 16'h0000;
  localparam logic [3:0]  RST_CTRL  = 4'h0;
  localparam logic [31:0] RD_ZERO   = 32'h0000_0000;
endpackage

// ---- design/rne_top.sv ----
// Event flags, masks and interrupt source logic of the ring node
`timescale 1ns/1ns
module rne_top
  import rne_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  // Avalon-MM slave
  input  wire logic [10:0] address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  // Conditions for restricted writes
  input  wire logic        maintenance_state_i,
  input  wire logic        noise_timing_i,
  input  wire logic        signaling_i,
  input  wire logic        media_access_on_i,
  // Physical-layer events
  input  wire logic        signal_presence_input_i,
  input  wire logic        link_error_threshold_hit_i,
  input  wire logic        min_idle_drop_i,
  input  wire logic        min_idle_gap_inc_i,
  input  wire logic        min_idle_gap_ovf_i,
  input  wire logic        violation_symbol_inc_i,
  input  wire logic        violation_symbol_ovf_i,
  input  wire logic        phy_layer_invalid_event_i,
  input  wire logic        elastic_buffer_fault_i,
  input  wire logic        line_idle_or_active_i,
  input  wire logic        noise_timer_zero_i,
  input  wire logic        conn_timer_zero_i,
  input  wire logic        join_asserted_i,
  input  wire logic        scrub_done_i,
  input  wire logic        conn_active_i,
  input  wire logic        break_entry_i,
  input  wire logic        quiet_halt_in_trace_i,
  input  wire logic        master_line_in_trace_i,
  input  wire logic        vector_exchange_done_i,
  input  wire logic        confidence_test_done_i,
  input  wire logic [2:0]  line_state_i,
  input  wire logic [2:0]  line_state_compare_field_i,
  input  wire logic        tx_parity_error_i,
  input  wire logic        phy_selftest_finished_i,
  // Media-access events
  input  wire logic        phy_invalid_symbol_seen_i,
  input  wire logic        rx_operational_i,
  input  wire logic        token_seen_i,
  input  wire logic        token_restricted_i,
  input  wire logic        tx_leave_idle_i,
  input  wire logic        tx_by_token_i,
  input  wire logic        own_beacon_i,
  input  wire logic        other_beacon_i,
  input  wire logic        e_indicator_r_i,
  input  wire logic        mac_selftest_finished_i,
  // Interrupt outputs
  output logic             shared_irq_pin_o,
  output logic             host_irq_status_bit_o,
  output logic             rx_go_listen_o
);

  //--------------------------------------------------------------------
  // Bus decode
  //--------------------------------------------------------------------
  logic [15:0] phy_flags_ff, mac_flags_ff, phy_mask_ff, mac_mask_ff;
  logic        glb_flag_ff, glb_mask_ff;
  logic [3:0]  ctrl_ff;
  logic [2:0]  src_ff;
  logic        wait_ff, irq_ff, status_ff, listen_ff;
  logic [31:0] rdata_ff;

  function automatic logic hit(input logic [8:0] a, input logic [8:0] idx);
    hit = (a == idx);
  endfunction

  wire [8:0] idx        = address_i[10:2];
  wire       req        = read_i | write_i;
  wire       fire       = req & ~wait_ff;
  wire       is_flags   = hit(idx, IDX_PHY_FLAGS) | hit(idx, IDX_MAC_FLAGS)
                        | hit(idx, IDX_GLB_FLAGS);
  wire       is_ro      = is_flags | hit(idx, IDX_IRQ_SRC);
  wire       is_rw      = hit(idx, IDX_PHY_MASK) | hit(idx, IDX_MAC_MASK)
                        | hit(idx, IDX_GLB_MASK) | hit(idx, IDX_CTRL);
  wire       is_wo      = hit(idx, IDX_CONN_LOAD) | hit(idx, IDX_NOISE_LOAD)
                        | hit(idx, IDX_TX_VECTOR) | hit(idx, IDX_VEC_LENGTH)
                        | hit(idx, IDX_MAC_CWRITE);
  wire       undefined  = ~(is_ro | is_rw | is_wo);
  wire       bad_time   = (hit(idx, IDX_CONN_LOAD) & ~maintenance_state_i)
                        | (hit(idx, IDX_NOISE_LOAD) & (~maintenance_state_i | noise_timing_i))
                        | ((hit(idx, IDX_TX_VECTOR) | hit(idx, IDX_VEC_LENGTH)) & signaling_i)
                        | (hit(idx, IDX_MAC_CWRITE) & media_access_on_i);
  wire       access_bad = fire & (undefined | (write_i & is_ro) | (read_i & is_wo)
                        | (write_i & bad_time));
  wire       wr_ok      = fire & write_i;
  wire       clr_phy    = fire & read_i & hit(idx, IDX_PHY_FLAGS);
  wire       clr_mac    = fire & read_i & hit(idx, IDX_MAC_FLAGS);
  wire       clr_glb    = fire & read_i & hit(idx, IDX_GLB_FLAGS);

  //--------------------------------------------------------------------
  // Event sources
  //--------------------------------------------------------------------
  logic       sig_meta_ff, sig_sync_ff, sig_last_ff, join_last_ff, lseq_last_ff, ebuf_ff;
  logic       phy_fin_ff, mac_fin_ff;
  wire        join_now = join_asserted_i & scrub_done_i & conn_active_i;
  wire        lseq_now = (line_state_i == line_state_compare_field_i);
  wire        mini_ev  = min_idle_drop_i
                       | (ctrl_ff[CTRL_MINI_OVF] ? min_idle_gap_ovf_i : min_idle_gap_inc_i);
  wire        vsym_ev  = ctrl_ff[CTRL_VSYM_OVF] ? violation_symbol_ovf_i
                                                : violation_symbol_inc_i;
  logic [15:0] phy_set, mac_set;

  always_comb begin
    phy_set             = 16'h0000;
    phy_set[PB_SIGNAL]  = sig_sync_ff & ~sig_last_ff;
    phy_set[PB_LINKERR] = link_error_threshold_hit_i;
    phy_set[PB_MINI]    = mini_ev;
    phy_set[PB_VSYM]    = vsym_ev;
    phy_set[PB_PHY_LAYER_INVALID_EVENT]  = phy_layer_invalid_event_i;
    phy_set[PB_EBUF]    = ebuf_ff;
    phy_set[PB_NOISE]   = noise_timer_zero_i;
    phy_set[PB_CONN]    = conn_timer_zero_i;
    phy_set[PB_JOIN]    = join_now & ~join_last_ff;
    phy_set[PB_BREAK]   = break_entry_i;
    phy_set[PB_QUIET]   = quiet_halt_in_trace_i;
    phy_set[PB_MASTER]  = master_line_in_trace_i;
    phy_set[PB_CODE]    = vector_exchange_done_i | confidence_test_done_i;
    phy_set[PB_LSEQ]    = lseq_now & ~lseq_last_ff;
    phy_set[PB_PARITY]  = tx_parity_error_i;
    mac_set             = 16'h0000;
    mac_set[MB_PHY_LAYER_INVALID_EVENT]  = phy_invalid_symbol_seen_i;
    mac_set[MB_UTOKEN]  = token_seen_i & ~token_restricted_i;
    mac_set[MB_RTOKEN]  = token_seen_i & token_restricted_i;
    mac_set[MB_TAKEN]   = tx_leave_idle_i & tx_by_token_i;
    mac_set[MB_BEACON]  = (own_beacon_i | other_beacon_i) & e_indicator_r_i;
  end

  // Pin synchroniser, edge trackers and held buffer fault
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sig_meta_ff  <= 1'b0;
      sig_sync_ff  <= 1'b0;
      sig_last_ff  <= 1'b0;
      join_last_ff <= 1'b0;
      lseq_last_ff <= 1'b0;
      ebuf_ff      <= 1'b0;
    end else begin
      sig_meta_ff  <= signal_presence_input_i;
      sig_sync_ff  <= sig_meta_ff;
      sig_last_ff  <= sig_sync_ff;
      join_last_ff <= join_now;
      lseq_last_ff <= lseq_now;
      ebuf_ff      <= elastic_buffer_fault_i | (ebuf_ff & ~line_idle_or_active_i);
    end
  end

  //--------------------------------------------------------------------
  // Event flag registers
  //--------------------------------------------------------------------
  // Only bits already returned to software are cleared, so a new event wins
  wire [15:0] snap         = rdata_ff[15:0];
  wire [15:0] nxt_phy      = ((clr_phy ? (phy_flags_ff & ~snap) : phy_flags_ff) | phy_set)
                           & 16'h7FFF;
  wire [15:0] nxt_mac      = ((clr_mac ? (mac_flags_ff & ~snap) : mac_flags_ff) | mac_set)
                           & 16'hF800;
  wire        nxt_glb      = (glb_flag_ff & ~(clr_glb & snap[0])) | access_bad;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phy_flags_ff <= RST_FLAGS;
      mac_flags_ff <= RST_FLAGS;
      glb_flag_ff  <= 1'b0;
    end else begin
      phy_flags_ff <= nxt_phy;
      mac_flags_ff <= nxt_mac;
      glb_flag_ff  <= nxt_glb;
    end
  end

  //--------------------------------------------------------------------
  // Masks and control
  //--------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phy_mask_ff <= RST_MASK;
      mac_mask_ff <= RST_MASK;
      glb_mask_ff <= 1'b0;
      ctrl_ff     <= RST_CTRL;
    end else if (wr_ok) begin
      if (hit(idx, IDX_PHY_MASK))
        phy_mask_ff <= writedata_i[15:0];
      if (hit(idx, IDX_MAC_MASK))
        mac_mask_ff <= writedata_i[15:0];
      if (hit(idx, IDX_GLB_MASK))
        glb_mask_ff <= writedata_i[0];
      if (hit(idx, IDX_CTRL))
        ctrl_ff <= writedata_i[3:0];
    end
  end

  // Self-test done latches while run is set and leaves with the run bit
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phy_fin_ff <= 1'b0;
      mac_fin_ff <= 1'b0;
    end else begin
      phy_fin_ff <= ctrl_ff[CTRL_PHY_RUN] & (phy_fin_ff | phy_selftest_finished_i);
      mac_fin_ff <= ctrl_ff[CTRL_MAC_RUN] & (mac_fin_ff | mac_selftest_finished_i);
    end
  end

  //--------------------------------------------------------------------
  // Interrupt combine
  //--------------------------------------------------------------------
  wire phy_cause = ctrl_ff[CTRL_PHY_RUN] ? phy_fin_ff
                                         : |(phy_flags_ff & phy_mask_ff);
  wire mac_cause = ctrl_ff[CTRL_MAC_RUN] ? mac_fin_ff
                                         : |(mac_flags_ff & mac_mask_ff);
  wire glb_cause = glb_flag_ff & glb_mask_ff;
  wire any_cause = phy_cause | mac_cause | glb_cause;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_ff    <= 3'h0;
      irq_ff    <= 1'b0;
      status_ff <= 1'b0;
      listen_ff <= 1'b0;
    end else begin
      src_ff    <= {glb_cause, mac_cause, phy_cause};
      irq_ff    <= any_cause;
      status_ff <= any_cause;
      listen_ff <= phy_invalid_symbol_seen_i & rx_operational_i;
    end
  end

  //--------------------------------------------------------------------
  // Read data and wait
  //--------------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = RD_ZERO;
    if (hit(idx, IDX_PHY_FLAGS))
      rd_mux[15:0] = phy_flags_ff;
    if (hit(idx, IDX_MAC_FLAGS))
      rd_mux[15:0] = mac_flags_ff;
    if (hit(idx, IDX_GLB_FLAGS))
      rd_mux[0] = glb_flag_ff;
    if (hit(idx, IDX_PHY_MASK))
      rd_mux[15:0] = phy_mask_ff;
    if (hit(idx, IDX_MAC_MASK))
      rd_mux[15:0] = mac_mask_ff;
    if (hit(idx, IDX_GLB_MASK))
      rd_mux[0] = glb_mask_ff;
    if (hit(idx, IDX_IRQ_SRC))
      rd_mux[2:0] = src_ff;
    if (hit(idx, IDX_CTRL))
      rd_mux[3:0] = ctrl_ff;
  end

  // Data is sampled one edge before the answer and held through it
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_ff  <= 1'b1;
      rdata_ff <= RD_ZERO;
    end else begin
      wait_ff  <= ~(req & wait_ff);
      if (req & wait_ff)
        rdata_ff <= read_i ? rd_mux : RD_ZERO;
    end
  end

  assign readdata_o            = rdata_ff;
  assign waitrequest_o         = wait_ff;
  assign shared_irq_pin_o      = irq_ff;
  assign host_irq_status_bit_o = status_ff;
  assign rx_go_listen_o        = listen_ff;

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  a_read_clears_phy: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    clr_phy |=> ((phy_flags_ff & $past(snap) & ~$past(phy_set)) == 16'h0000))
    else $error("read did not clear physical-layer flags");

  a_set_wins_clear: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (clr_mac && mac_set[MB_RTOKEN]) |=> mac_flags_ff[MB_RTOKEN])
    else $error("event lost during clearing read");

  a_irq_follows_cause: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (glb_flag_ff && glb_mask_ff)
      |=> (shared_irq_pin_o && host_irq_status_bit_o && src_ff[SRC_GLB]))
    else $error("interrupt not raised for masked global event");

  a_irq_drops_free: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !any_cause |=> !shared_irq_pin_o)
    else $error("interrupt held without a cause");

  a_selftest_gate: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (ctrl_ff[CTRL_PHY_RUN] && !phy_fin_ff) |=> !src_ff[SRC_PHY])
    else $error("physical-layer interrupt not masked in self-test");

  a_undefined_fault: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (fire && undefined) |=> glb_flag_ff)
    else $error("undefined access did not set fault");

  a_timed_write: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (fire && write_i && hit(idx, IDX_CONN_LOAD) && !maintenance_state_i) |=> glb_flag_ff)
    else $error("restricted write did not set fault");

  a_reserved_zero: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !phy_flags_ff[15] && (mac_flags_ff[10:0] == 11'h000))
    else $error("reserved flag bit set");

  a_ebuf_hold: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (elastic_buffer_fault_i ##1 !line_idle_or_active_i) |=> phy_flags_ff[PB_EBUF])
    else $error("buffer fault released before line state");

  a_beacon_needs_r: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (!mac_flags_ff[MB_BEACON] && !e_indicator_r_i) |=> !mac_flags_ff[MB_BEACON])
    else $error("beacon flag set without R indicator");

  a_wait_one: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (req && wait_ff) |=> !waitrequest_o ##1 waitrequest_o)
    else $error("answer not given one cycle after request");

  a_signal_edge: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $rose(sig_sync_ff) |=> phy_flags_ff[PB_SIGNAL])
    else $error("signal presence edge not latched");

  a_timer_zero: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    conn_timer_zero_i |=> phy_flags_ff[PB_CONN])
    else $error("connection timer expiry not latched");

  a_listen_entry: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (phy_invalid_symbol_seen_i && rx_operational_i)
      |=> (rx_go_listen_o && mac_flags_ff[MB_PHY_LAYER_INVALID_EVENT]))
    else $error("invalid symbol did not send receiver to listen");

  a_free_token: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (token_seen_i && !token_restricted_i) |=> mac_flags_ff[MB_UTOKEN])
    else $error("unrestricted token not latched");

endmodule

// ---- verif/rne_host_model.sv ----
// Node processor model: Avalon-MM master that reads and writes the event registers
`timescale 1ns/1ns
module rne_host_model
  import rne_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        waitrequest_i,
  input  wire logic        slow_i,
  output logic [10:0]      address_o,
  output logic             read_o,
  output logic             write_o,
  output logic [31:0]      writedata_o
);
  // No parity path in an end station, so that event stays masked
  localparam logic [15:0] PHY_MASK_END = 16'h7FFE;

  initial begin
    address_o = 11'h000;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0000_0000;
  end

  // One transfer; slow mode leaves random idle cycles before the request
  task automatic xfer(input logic wr, input logic [8:0] idx, input logic [31:0] wd);
    int gap;
    gap = slow_i ? int'($urandom_range(3)) : 0;
    repeat (gap + 1) @(posedge clock_i);
    address_o   <= {idx, 2'b00};
    read_o      <= ~wr;
    write_o     <= wr;
    writedata_o <= wd;
    @(posedge clock_i);
    while (waitrequest_i !== 1'b0) @(posedge clock_i);
    read_o  <= 1'b0;
    write_o <= 1'b0;
  endtask
endmodule

// ---- verif/tb_ring_node_interrupt_events.sv ----
// Self-checking bench for the node event flags, masks and interrupt outputs
`timescale 1ns/1ns
module tb_ring_node_interrupt_events;
  import rne_pkg::*;
  logic        clock_i;
  logic        reset_n_i;
  logic [10:0] addr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        rd_en;
  logic        wr_en;
  logic        wreq;
  logic        slow;
  logic [15:0] pe;
  logic [15:0] me;
  logic [5:0]  mx;
  logic [2:0]  ls;
  logic [2:0]  lcf;
  logic        sig, lia, jn, sc, ca, rxop, tres, tbt, er, mnt, nt, sg, mon, irq, hst, lsn;
  logic [31:0] expq[$];
  int          err_total;
  int          checks_done;
  logic [8:0]  regs [8];
  int          bits [11];

  rne_host_model host (.clock_i(clock_i), .waitrequest_i(wreq), .slow_i(slow),
    .address_o(addr), .read_o(rd_en), .write_o(wr_en), .writedata_o(wdat));

  rne_top uut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .address_i(addr), .read_i(rd_en),
    .write_i(wr_en), .writedata_i(wdat), .readdata_o(rdat), .waitrequest_o(wreq),
    .maintenance_state_i(mnt), .noise_timing_i(nt), .signaling_i(sg), .media_access_on_i(mon),
    .signal_presence_input_i(sig), .link_error_threshold_hit_i(pe[13]),
    .min_idle_drop_i(pe[12]), .min_idle_gap_inc_i(mx[0]), .min_idle_gap_ovf_i(mx[1]),
    .violation_symbol_inc_i(pe[11]), .violation_symbol_ovf_i(mx[2]),
    .phy_layer_invalid_event_i(pe[10]), .elastic_buffer_fault_i(pe[9]),
    .line_idle_or_active_i(lia), .noise_timer_zero_i(pe[8]), .conn_timer_zero_i(pe[7]),
    .join_asserted_i(jn), .scrub_done_i(sc), .conn_active_i(ca), .break_entry_i(pe[5]),
    .quiet_halt_in_trace_i(pe[4]), .master_line_in_trace_i(pe[3]),
    .vector_exchange_done_i(pe[2]), .confidence_test_done_i(mx[3]), .line_state_i(ls),
    .line_state_compare_field_i(lcf), .tx_parity_error_i(pe[0]),
    .phy_selftest_finished_i(mx[4]), .phy_invalid_symbol_seen_i(me[15]),
    .rx_operational_i(rxop), .token_seen_i(me[14]), .token_restricted_i(tres),
    .tx_leave_idle_i(me[12]), .tx_by_token_i(tbt), .own_beacon_i(me[11]),
    .other_beacon_i(me[10]), .e_indicator_r_i(er), .mac_selftest_finished_i(mx[5]),
    .shared_irq_pin_o(irq), .host_irq_status_bit_o(hst), .rx_go_listen_o(lsn));

  //--------------------------------------------------------------------
  // Helpers
  //--------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [8:0] idx, input logic [31:0] exp);
    expq.push_back(exp);
    host.xfer(1'b0, idx, 32'h0000_0000);
  endtask
  task automatic wr(input logic [8:0] idx, input logic [31:0] d);
    host.xfer(1'b1, idx, d);
  endtask
  task automatic pulse(input logic [15:0] p, input logic [15:0] m, input logic [5:0] x);
    @(posedge clock_i);
    pe <= p;
    me <= m;
    mx <= x;
    @(posedge clock_i);
    pe <= 16'h0000;
    me <= 16'h0000;
    mx <= 6'h00;
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    check({30'h0, irq, hst}, {30'h0, v, v});
  endtask
  task automatic fcase(input logic w, input logic [8:0] idx, input logic [3:0] c,
                       input logic [31:0] e);
    {mnt, nt, sg, mon} <= c;
    if (!w) expq.push_back(RD_ZERO);
    host.xfer(w, idx, $urandom);
    rd(IDX_GLB_FLAGS, e);
  endtask
  task automatic close_out;
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Read results are taken at the edge where the master sees the answer
  always @(posedge clock_i) begin
    if (rd_en === 1'b1 && wreq === 1'b0) begin
      if (expq.size() == 0) check(rdat, 32'hFFFF_FFFF);
      else check(rdat, expq.pop_front());
    end
  end

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    close_out();
  end

  //--------------------------------------------------------------------
  // Tests
  //--------------------------------------------------------------------
  initial begin
    void'($urandom(4354));
    {pe, me, mx, sig, lia, jn, sc, ca, tres, tbt, er, mnt, nt, sg, mon, slow} = '0;
    ls = 3'h0;
    lcf = 3'h7;
    rxop = 1'b1;
    err_total = 0;
    checks_done = 0;
    regs = '{IDX_PHY_FLAGS, IDX_MAC_FLAGS, IDX_GLB_FLAGS, IDX_IRQ_SRC,
             IDX_PHY_MASK, IDX_MAC_MASK, IDX_GLB_MASK, IDX_CTRL};
    bits = '{13, 12, 11, 10, 8, 7, 5, 4, 3, 2, 0};
    reset_n_i = 1'b0;
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1'b1;
    foreach (regs[i]) rd(regs[i], RD_ZERO);
    $display("reset values done");
    slow <= 1'b1;
    foreach (bits[i]) begin
      pulse(16'h0001 << bits[i], 16'h0000, 6'h00);
      rd(IDX_PHY_FLAGS, 32'h1 << bits[i]);
    end
    for (int m = 0; m < 2; m++) begin
      wr(IDX_CTRL, m ? 32'h0000_000C : 32'h0000_0000);
      pulse(16'h0800, 16'h0000, 6'h01);
      rd(IDX_PHY_FLAGS, m ? 32'h0 : 32'h1800);
      pulse(16'h0000, 16'h0000, 6'h06);
      rd(IDX_PHY_FLAGS, m ? 32'h1800 : 32'h0);
    end
    wr(IDX_CTRL, 32'h0);
    pulse(16'h0000, 16'h0000, 6'h08);
    rd(IDX_PHY_FLAGS, 32'h0004);
    {jn, sc, ca} <= 3'b111;
    ls <= 3'($urandom);
    @(posedge clock_i);
    lcf <= ls;
    sig <= 1'b1;
    repeat (5) @(posedge clock_i);
    rd(IDX_PHY_FLAGS, 32'h4042);
    pulse(16'h0200, 16'h0000, 6'h00);
    rd(IDX_PHY_FLAGS, 32'h0200);
    rd(IDX_PHY_FLAGS, 32'h0200);
    lia <= 1'b1;
    @(posedge clock_i);
    lia <= 1'b0;
    rd(IDX_PHY_FLAGS, 32'h0200);
    rd(IDX_PHY_FLAGS, 32'h0000);
    $display("physical-layer events done");
    pulse(16'h0000, 16'h8000, 6'h00);
    @(negedge clock_i);
    check({31'h0, lsn}, 32'h1);
    @(posedge clock_i);
    rxop <= 1'b0;
    pulse(16'h0000, 16'h8000, 6'h00);
    @(negedge clock_i);
    check({31'h0, lsn}, 32'h0);
    rd(IDX_MAC_FLAGS, 32'h8000);
    for (int t = 0; t < 2; t++) begin
      tres <= t[0];
      pulse(16'h0000, 16'h4000, 6'h00);
      rd(IDX_MAC_FLAGS, t ? 32'h2000 : 32'h4000);
    end
    for (int t = 0; t < 2; t++) begin
      {tbt, er} <= {t[0], t[0]};
      pulse(16'h0000, t ? 16'h1400 : 16'h1800, 6'h00);
      rd(IDX_MAC_FLAGS, t ? 32'h1800 : 32'h0);
    end
    $display("media-access events done");
    fcase(1'b0, 9'h000, 4'h0, 32'h1);
    fcase(1'b1, 9'h001, 4'h0, 32'h1);
    fcase(1'b1, IDX_PHY_FLAGS, 4'h0, 32'h1);
    rd(IDX_PHY_FLAGS, RD_ZERO);
    fcase(1'b1, IDX_IRQ_SRC, 4'h0, 32'h1);
    fcase(1'b0, IDX_CONN_LOAD, 4'h0, 32'h1);
    fcase(1'b1, IDX_CONN_LOAD, 4'h0, 32'h1);
    fcase(1'b1, IDX_CONN_LOAD, 4'h8, 32'h0);
    fcase(1'b1, IDX_NOISE_LOAD, 4'hC, 32'h1);
    fcase(1'b1, IDX_NOISE_LOAD, 4'h8, 32'h0);
    fcase(1'b1, IDX_TX_VECTOR, 4'h2, 32'h1);
    fcase(1'b1, IDX_VEC_LENGTH, 4'h2, 32'h1);
    fcase(1'b1, IDX_VEC_LENGTH, 4'h0, 32'h0);
    fcase(1'b1, IDX_MAC_CWRITE, 4'h1, 32'h1);
    fcase(1'b1, IDX_MAC_CWRITE, 4'h0, 32'h0);
    $display("access faults done");
    slow <= 1'b0;
    wr(IDX_PHY_MASK, {16'h0, host.PHY_MASK_END});
    pulse(16'h0001, 16'h0000, 6'h00);
    irq_is(1'b0);
    pulse(16'h0100, 16'h0000, 6'h00);
    irq_is(1'b1);
    rd(IDX_IRQ_SRC, 32'h1);
    wr(IDX_PHY_MASK, 32'h0);
    irq_is(1'b0);
    wr(IDX_PHY_MASK, 32'h7FFE);
    irq_is(1'b1);
    rd(IDX_PHY_FLAGS, 32'h0101);
    irq_is(1'b0);
    wr(IDX_MAC_MASK, 32'h8000);
    wr(IDX_GLB_MASK, 32'h1);
    pulse(16'h0000, 16'h8000, 6'h00);
    fcase(1'b0, 9'h000, 4'h0, 32'h1);
    rd(IDX_IRQ_SRC, 32'h2);
    rd(IDX_MAC_FLAGS, 32'h8000);
    irq_is(1'b0);
    $display("interrupt paths done");
    for (int c = 0; c < 2; c++) begin
      wr(IDX_CTRL, 32'h1 << c);
      pulse(c ? 16'h0 : 16'h0100, c ? 16'h8000 : 16'h0, 6'h00);
      irq_is(1'b0);
      pulse(16'h0000, 16'h0000, 6'h10 << c);
      irq_is(1'b1);
      rd(c ? IDX_MAC_FLAGS : IDX_PHY_FLAGS, c ? 32'h8000 : 32'h0100);
      irq_is(1'b1);
      wr(IDX_CTRL, 32'h0);
      irq_is(1'b0);
    end
    $display("self-test masking done");
    fork
      rd(IDX_PHY_FLAGS, RD_ZERO);
      begin
        repeat (2) @(posedge clock_i);
        pe <= 16'h0080;
        @(posedge clock_i);
        pe <= 16'h0000;
      end
    join
    rd(IDX_PHY_FLAGS, 32'h0080);
    $display("read collision done");
    repeat (3) @(posedge clock_i);
    close_out();
  end
endmodule
